// File: logic/asf_pkg.sv
// ----------------------------------------------------------------------------
// asf_pkg: shared constants for the smoke-alarm front-end control block
// ----------------------------------------------------------------------------
// assumes a 250 MHz system clock and a 32-bit APB register bus
package asf_pkg;
   // clock rate and documented times
   localparam int CLK_FREQ_MHZ = 250;
   localparam int LDO_DEGLITCH_US = 125;
   localparam int LDO_MASK_MS = 10;
   localparam int LDO_DEGLITCH_CYC = LDO_DEGLITCH_US * CLK_FREQ_MHZ;
   localparam int LDO_MASK_CYC = LDO_MASK_MS * 1000 * CLK_FREQ_MHZ;
   localparam int MS_PER_SEC = 1000;
   localparam int LF_TICKS_PER_MS_DEF = 32;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PINCFG = 8'h04;
   localparam logic [7:0] ADDR_MASK = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_SLPCFG = 8'h10;
   localparam logic [7:0] ADDR_SLPCTL = 8'h14;
   localparam logic [7:0] ADDR_PERLO = 8'h18;
   localparam logic [7:0] ADDR_PERHI = 8'h1c;
   localparam logic [7:0] ADDR_EFFECT = 8'h20;
   // control register fields
   localparam int CT_SND_TYPE = 0;
   localparam int CT_SND_EN = 1;
   localparam int CT_BATT = 2;
   localparam int CT_PAMP = 3;
   localparam int CT_BOOST = 4;
   localparam int CT_AMUX = 5;
   localparam int CT_LEDREG = 8;
   localparam int CT_PGAIN = 9;
   localparam int CT_LEDGATE = 10;
   localparam int CT_OTSMON = 11;
   localparam int CT_LDO = 12;
   localparam int CT_LDOFDIS = 13;
   localparam int CT_LDOV = 15;
   localparam int CTRL_W = 18;
   // pin configuration fields
   localparam int PC_GPIO = 0;
   localparam int PC_ROUTE = 2;
   localparam int PC_ICON = 3;
   localparam int PC_ICDIR = 4;
   localparam logic [1:0] GPIO_FN_BATT = 2'h1;
   localparam logic [1:0] GPIO_FN_IRQ = 2'h2;
   // sleep configuration and status flag positions
   localparam int SC_ANALOG = 0;
   localparam int SC_BOOST = 1;
   localparam int SC_LDO = 2;
   localparam int ST_IC = 0;
   localparam int ST_OTS = 4;
   localparam int ST_LDO = 5;
   localparam int ST_SLPDONE = 7;
   // fault state machine
   typedef enum logic [1:0] {FS_NORMAL, FS_LDO, FS_OTS} asf_fault_e;
endpackage

// File: logic/asf_ctrl.sv
// ----------------------------------------------------------------------------
// asf_ctrl: sounder, bias, interrupt, sleep and fault control of the front end
// ----------------------------------------------------------------------------
// assumes pins and the low-frequency clock arrive asynchronously, APB master
// on clk_sys, and analog comparators that present plain logic levels
//
// Contract
// - one type bit selects three-terminal resonant or two-terminal driven sounder
// - three-terminal oscillation needs both enable bit and enable pin high
// - two-terminal mode copies feedback pin to silver and enable pin to brass
// - battery load on from its bit, or from GPIO setting with GPIO pin
// - bias block on whenever any connected function is active, except battery load switched on from the GPIO pin
// - 8 MHz oscillator runs only with boost or photo amplifier enabled
// - each status flag reaches the interrupt only through its own mask bit
// - interrupt on GPIO when function is 0x2, on alert pin when routed
// - interrupt holds until status read; read clears only vanished conditions
// - interconnect on: direction 0 outputs line, direction 1 alert pin controls driver
// - sleep request starts the timer and disables configured blocks
// - timer expiry clears sleep request and latches the done flag
// - writing zero leaves sleep at once without the done flag
// - analog-off option drops amplifiers and drivers together on sleep entry
// - boost and regulator off during sleep when selected, restored on exit
// - sleep period 1 to 65535 ms in 1 ms steps over two registers
// - sleep suspends only fault state entry; pending faults enter at exit
// - regulator undervoltage deglitched 125 us, active while regulator enabled
// - regulator fault flag after 10 ms mask; fault state unless disabled
// - regulator fault forces boost and temperature monitor on, regulator stays on, amplifiers and drivers off
// - regulator fault left on good power at second check or status read
// - over-temperature in regulator fault also drops regulator, returns afterwards
// - over-temperature fault left when check or read finds die cool
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module asf_ctrl #(
   parameter int LF_TICKS_PER_MS = asf_pkg::LF_TICKS_PER_MS_DEF,
   parameter int DEGLITCH_CYC = asf_pkg::LDO_DEGLITCH_CYC,
   parameter int MASK_CYC = asf_pkg::LDO_MASK_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // asynchronous pins and comparators
   input wire logic sounder_enable_pin,
   input wire logic feedback_input,
   input wire logic led_drive_pin,
   input wire logic interconnectLine,
   input wire logic ldoUvGoodRaw,
   input wire logic dieHot,
   input wire logic dieCool,
   input wire logic lfClk,
   // two-way pins
   input wire logic gpioIn,
   output logic gpioOut,
   output logic gpioOeN,
   input wire logic hostAlertIn,
   output logic hostAlertOut,
   output logic hostAlertOeN,
   // sounder outputs
   output logic silver_output,
   output logic brass_output,
   output logic sounderOscOn,
   // analog enables
   output logic batteryLoadEn,
   output logic biasEn,
   output logic osc8mEn,
   output logic boostEn,
   output logic ldoEn,
   output logic photoAmpEn,
   output logic photoGainEn,
   output logic ledRegEn,
   output logic ledDriveEn,
   output logic amuxEn,
   output logic otsMonEn,
   output logic interconnectDrive
);
   localparam int NPIN = 10;
   localparam int P_SND = 0;
   localparam int P_FB = 1;
   localparam int P_LED = 2;
   localparam int P_GPIO = 3;
   localparam int P_ALERT = 4;
   localparam int P_IC = 5;
   localparam int P_PG = 6;
   localparam int P_HOT = 7;
   localparam int P_COOL = 8;
   localparam int P_LF = 9;

   // ------------------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------------------
   if (LF_TICKS_PER_MS < 1 || LF_TICKS_PER_MS > 65535)
   begin : g_bad_lf
      $error("LF_TICKS_PER_MS out of range");
   end
   if (DEGLITCH_CYC < 1 || DEGLITCH_CYC > 65535)
   begin : g_bad_dg
      $error("DEGLITCH_CYC out of range");
   end
   if (MASK_CYC < 1 || MASK_CYC > 16777215)
   begin : g_bad_mask
      $error("MASK_CYC out of range");
   end

   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   typedef struct packed {
      logic [NPIN-1:0] sync1;
      logic [NPIN-1:0] sync2;
      logic lfPrev;
      logic [asf_pkg::CTRL_W-1:0] ctrl;
      logic [4:0] pinCfg;
      logic [7:0] mask;
      logic [7:0] flags;
      logic [2:0] slpCfg;
      logic sleepReq;
      logic [15:0] period;
      logic [15:0] msLeft;
      logic [15:0] lfCnt;
      logic [9:0] msInSec;
      logic [15:0] dgCnt;
      logic pgFilt;
      logic [23:0] maskCnt;
      asf_pkg::asf_fault_e fault;
      logic otsFromLdo;
      logic [31:0] rdata;
      logic rdy;
      logic err;
      logic [19:0] outs;
   } asf_state_s;

   asf_state_s s_q;
   asf_state_s s_d;
   logic [NPIN-1:0] pinsRaw;
   logic [NPIN-1:0] pin;
   logic lfTick, msTick, secTick, apbDone, apbWr, statusRd, sleepExpire;
   logic inFault, kill, ldoEffC, boostEffC, otsEffC, photoAmpC, ldoCond, otsCond, irq;
   logic [7:0] condLevel;
   logic [19:0] outsC;

   assign pinsRaw = {lfClk, dieCool, dieHot, ldoUvGoodRaw, interconnectLine, hostAlertIn, gpioIn,
                     led_drive_pin, feedback_input, sounder_enable_pin};
   assign pin = s_q.sync2;

   // decode of the register map, shared by read and write paths
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a[1:0] == 2'h0) && (a <= asf_pkg::ADDR_EFFECT);
   endfunction

   // read data mux; reserved bits read as zero
   function automatic logic [31:0] readMux(input logic [7:0] a, input asf_state_s s);
      readMux = 32'h0;
      case (a)
         asf_pkg::ADDR_CTRL: readMux[asf_pkg::CTRL_W-1:0] = s.ctrl;
         asf_pkg::ADDR_PINCFG: readMux[4:0] = s.pinCfg;
         asf_pkg::ADDR_MASK: readMux[7:0] = s.mask;
         asf_pkg::ADDR_STATUS: readMux[11:0] = {s.fault, s.pgFilt, s.sleepReq, s.flags};
         asf_pkg::ADDR_SLPCFG: readMux[2:0] = s.slpCfg;
         asf_pkg::ADDR_SLPCTL: readMux[0] = s.sleepReq;
         asf_pkg::ADDR_PERLO: readMux[7:0] = s.period[7:0];
         asf_pkg::ADDR_PERHI: readMux[7:0] = s.period[15:8];
         asf_pkg::ADDR_EFFECT: readMux[19:0] = s.outs;
         default: readMux = 32'h0;
      endcase
   endfunction

   // ------------------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      // two-stage synchronisers; only the second stage feeds logic
      s_d.sync1 = pinsRaw;
      s_d.sync2 = s_q.sync1;
      s_d.lfPrev = pin[P_LF];
      lfTick = pin[P_LF] & ~s_q.lfPrev;
      msTick = 1'b0;
      secTick = 1'b0;
      if (lfTick)
      begin
         if (s_q.lfCnt == 16'(LF_TICKS_PER_MS - 1))
         begin
            s_d.lfCnt = 16'h0;
            msTick = 1'b1;
         end
         else
            s_d.lfCnt = s_q.lfCnt + 16'h1;
      end
      if (msTick)
      begin
         if (s_q.msInSec == 10'(asf_pkg::MS_PER_SEC - 1))
         begin
            s_d.msInSec = 10'h0;
            secTick = 1'b1;
         end
         else
            s_d.msInSec = s_q.msInSec + 10'h1;
      end

      // apb: one wait state, data and answer registered
      apbDone = psel & penable & s_q.rdy;
      apbWr = apbDone & pwrite & isMapped(paddr);
      statusRd = apbDone & ~pwrite & (paddr == asf_pkg::ADDR_STATUS);
      s_d.rdy = psel & penable & ~s_q.rdy;
      s_d.err = psel & penable & ~s_q.rdy & ~isMapped(paddr);
      s_d.rdata = (psel & penable & ~s_q.rdy & ~pwrite) ? readMux(paddr, s_q) : 32'h0;
      if (apbWr)
      begin
         case (paddr)
            asf_pkg::ADDR_CTRL: s_d.ctrl = pwdata[asf_pkg::CTRL_W-1:0];
            asf_pkg::ADDR_PINCFG: s_d.pinCfg = pwdata[4:0];
            asf_pkg::ADDR_MASK: s_d.mask = pwdata[7:0];
            asf_pkg::ADDR_SLPCFG: s_d.slpCfg = pwdata[2:0];
            asf_pkg::ADDR_PERLO: s_d.period[7:0] = pwdata[7:0];
            asf_pkg::ADDR_PERHI: s_d.period[15:8] = pwdata[7:0];
            default: s_d.period = s_q.period;
         endcase
      end

      // effective enables from configuration, sleep and fault state
      inFault = (s_q.fault != asf_pkg::FS_NORMAL);
      kill = inFault | (s_q.sleepReq & s_q.slpCfg[asf_pkg::SC_ANALOG]);
      // regulator off in sleep when selected, off in temperature fault
      ldoEffC = s_q.ctrl[asf_pkg::CT_LDO] & (s_q.fault != asf_pkg::FS_OTS)
                & ~(s_q.sleepReq & s_q.slpCfg[asf_pkg::SC_LDO]);
      if (s_q.fault == asf_pkg::FS_LDO)
         boostEffC = 1'b1;
      else if (s_q.fault == asf_pkg::FS_OTS)
         boostEffC = 1'b0;
      else
         boostEffC = s_q.ctrl[asf_pkg::CT_BOOST] & ~(s_q.sleepReq & s_q.slpCfg[asf_pkg::SC_BOOST]);
      // the monitor stays on in both faults, otherwise the cool check could never pass
      otsEffC = s_q.ctrl[asf_pkg::CT_OTSMON] | inFault;
      photoAmpC = s_q.ctrl[asf_pkg::CT_PAMP] & ~kill;

      // deglitch of the regulator good level
      if (!ldoEffC)
      begin
         s_d.pgFilt = 1'b0;
         s_d.dgCnt = 16'h0;
      end
      else if (pin[P_PG] == s_q.pgFilt)
         s_d.dgCnt = 16'h0;
      else if (s_q.dgCnt == 16'(DEGLITCH_CYC - 1))
      begin
         s_d.pgFilt = pin[P_PG];
         s_d.dgCnt = 16'h0;
      end
      else
         s_d.dgCnt = s_q.dgCnt + 16'h1;
      // mask restarts on enable or a voltage change
      if (!ldoEffC || (apbWr && paddr == asf_pkg::ADDR_CTRL
          && pwdata[asf_pkg::CT_LDOV+:3] != s_q.ctrl[asf_pkg::CT_LDOV+:3]))
         s_d.maskCnt = 24'h0;
      else if (s_q.maskCnt != 24'(MASK_CYC))
         s_d.maskCnt = s_q.maskCnt + 24'h1;
      ldoCond = ldoEffC & ~s_q.pgFilt & (s_q.maskCnt == 24'(MASK_CYC));
      otsCond = otsEffC & pin[P_HOT];

      // sleep timer
      sleepExpire = s_q.sleepReq & msTick & (s_q.msLeft <= 16'h1);
      if (sleepExpire)
         s_d.sleepReq = 1'b0;
      else if (s_q.sleepReq & msTick)
         s_d.msLeft = s_q.msLeft - 16'h1;
      if (apbWr && paddr == asf_pkg::ADDR_SLPCTL)
      begin
         if (!pwdata[0])
            s_d.sleepReq = 1'b0;
         else if (!s_q.sleepReq)
         begin
            // timer start; zero period acts as one
            s_d.sleepReq = 1'b1;
            s_d.msLeft = (s_q.period == 16'h0) ? 16'h1 : s_q.period;
         end
      end

      // read clears only flags it returned whose cause is gone; set wins
      condLevel = 8'h0;
      condLevel[asf_pkg::ST_IC] = pin[P_IC];
      condLevel[asf_pkg::ST_OTS] = otsCond | (s_q.fault == asf_pkg::FS_OTS);
      condLevel[asf_pkg::ST_LDO] = ldoCond | (s_q.fault == asf_pkg::FS_LDO);
      if (statusRd)
         s_d.flags = s_q.flags & ~(s_q.rdata[7:0] & ~condLevel);
      s_d.flags = s_d.flags | condLevel;
      if (sleepExpire)
         s_d.flags[asf_pkg::ST_SLPDONE] = 1'b1;

      s_d.otsFromLdo = s_q.otsFromLdo;
      case (s_q.fault)
         asf_pkg::FS_NORMAL:
            if (!s_q.sleepReq && otsCond)
            begin
               s_d.fault = asf_pkg::FS_OTS;
               s_d.otsFromLdo = 1'b0;
            end
            else if (!s_q.sleepReq && ldoCond && !s_q.ctrl[asf_pkg::CT_LDOFDIS])
               s_d.fault = asf_pkg::FS_LDO;
         asf_pkg::FS_LDO:
            if (!s_q.sleepReq && otsCond)
            begin
               s_d.fault = asf_pkg::FS_OTS;
               s_d.otsFromLdo = 1'b1;
            end
            else if ((secTick || statusRd) && s_q.pgFilt)
               s_d.fault = asf_pkg::FS_NORMAL;
         asf_pkg::FS_OTS:
            if ((secTick || statusRd) && pin[P_COOL])
               s_d.fault = s_q.otsFromLdo ? asf_pkg::FS_LDO : asf_pkg::FS_NORMAL;
         default: s_d.fault = asf_pkg::FS_NORMAL;
      endcase

      irq = |(s_q.flags & s_q.mask);
      outsC = 20'h0;
      outsC[2] = ~s_q.ctrl[asf_pkg::CT_SND_TYPE] & s_q.ctrl[asf_pkg::CT_SND_EN] & pin[P_SND] & ~kill;
      outsC[0] = s_q.ctrl[asf_pkg::CT_SND_TYPE] & pin[P_FB] & ~kill;
      outsC[1] = s_q.ctrl[asf_pkg::CT_SND_TYPE] & pin[P_SND] & ~kill;
      outsC[3] = (s_q.ctrl[asf_pkg::CT_BATT]
                 | (s_q.pinCfg[asf_pkg::PC_GPIO+:2] == asf_pkg::GPIO_FN_BATT & pin[P_GPIO])) & ~kill;
      outsC[6] = boostEffC;
      outsC[7] = ldoEffC;
      outsC[8] = photoAmpC;
      outsC[9] = s_q.ctrl[asf_pkg::CT_PGAIN] & ~kill;
      outsC[10] = s_q.ctrl[asf_pkg::CT_LEDREG] & ~kill;
      outsC[11] = pin[P_LED] & s_q.ctrl[asf_pkg::CT_LEDGATE] & ~kill;
      outsC[12] = (s_q.ctrl[asf_pkg::CT_AMUX+:3] != 3'h0) & ~kill;
      outsC[13] = otsEffC;
      outsC[4] = photoAmpC | boostEffC | outsC[12] | (s_q.ctrl[asf_pkg::CT_SND_EN] & ~kill) | outsC[10]
                 | outsC[9] | (s_q.ctrl[asf_pkg::CT_BATT] & ~kill) | outsC[11] | otsEffC;
      // oscillator from boost or photo amplifier
      outsC[5] = boostEffC | photoAmpC;
      outsC[14] = (s_q.pinCfg[asf_pkg::PC_GPIO+:2] == asf_pkg::GPIO_FN_IRQ) & irq;
      outsC[15] = s_q.pinCfg[asf_pkg::PC_GPIO+:2] != asf_pkg::GPIO_FN_IRQ;
      // interconnect use of the alert pin, else routing
      if (s_q.pinCfg[asf_pkg::PC_ICON])
      begin
         outsC[16] = ~s_q.pinCfg[asf_pkg::PC_ICDIR] & pin[P_IC];
         outsC[17] = s_q.pinCfg[asf_pkg::PC_ICDIR];
         outsC[18] = s_q.pinCfg[asf_pkg::PC_ICDIR] & pin[P_ALERT];
      end
      else
      begin
         outsC[16] = s_q.pinCfg[asf_pkg::PC_ROUTE] & irq;
         outsC[17] = ~s_q.pinCfg[asf_pkg::PC_ROUTE];
         outsC[18] = 1'b0;
      end
      s_d.outs = outsC;
   end

   // ------------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------------
   // oe-low bits reset high so no pin is driven out of reset
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         s_q <= '0;
         s_q.outs <= 20'h28000;
      end
      else
         s_q <= s_d;
   end

   // outputs straight from the state register
   assign prdata = s_q.rdata;
   assign pready = s_q.rdy;
   assign pslverr = s_q.err;
   assign silver_output = s_q.outs[0];
   assign brass_output = s_q.outs[1];
   assign sounderOscOn = s_q.outs[2];
   assign batteryLoadEn = s_q.outs[3];
   assign biasEn = s_q.outs[4];
   assign osc8mEn = s_q.outs[5];
   assign boostEn = s_q.outs[6];
   assign ldoEn = s_q.outs[7];
   assign photoAmpEn = s_q.outs[8];
   assign photoGainEn = s_q.outs[9];
   assign ledRegEn = s_q.outs[10];
   assign ledDriveEn = s_q.outs[11];
   assign amuxEn = s_q.outs[12];
   assign otsMonEn = s_q.outs[13];
   assign gpioOut = s_q.outs[14];
   assign gpioOeN = s_q.outs[15];
   assign hostAlertOut = s_q.outs[16];
   assign hostAlertOeN = s_q.outs[17];
   assign interconnectDrive = s_q.outs[18];

   // ------------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------------
   property p_sound3;
      @(posedge clk_sys) disable iff (reset)
      (!s_q.ctrl[asf_pkg::CT_SND_TYPE] && s_q.ctrl[asf_pkg::CT_SND_EN] && pin[P_SND] && !kill)
      |=> sounderOscOn;
   endproperty
   a_sound3: assert property (p_sound3) else $error("sounder did not start");
   property p_twoTerm;
      @(posedge clk_sys) disable iff (reset)
      (s_q.ctrl[asf_pkg::CT_SND_TYPE] && !kill) |=> (silver_output == $past(pin[P_FB]))
      && (brass_output == $past(pin[P_SND])) && !sounderOscOn;
   endproperty
   a_twoTerm: assert property (p_twoTerm) else $error("two-terminal copy wrong");
   property p_osc;
      @(posedge clk_sys) disable iff (reset)
      ##1 osc8mEn == $past(boostEffC || photoAmpC);
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator enable wrong");
   property p_gpioIrq;
      @(posedge clk_sys) disable iff (reset)
      (s_q.pinCfg[1:0] == asf_pkg::GPIO_FN_IRQ) |=> !gpioOeN && gpioOut == $past(|(s_q.flags & s_q.mask));
   endproperty
   a_gpioIrq: assert property (p_gpioIrq) else $error("gpio interrupt wrong");
   property p_hold;
      @(posedge clk_sys) disable iff (reset)
      (s_q.flags[asf_pkg::ST_SLPDONE] && !statusRd) |=> s_q.flags[asf_pkg::ST_SLPDONE];
   endproperty
   a_hold: assert property (p_hold) else $error("flag lost without read");
   property p_earlyExit;
      @(posedge clk_sys) disable iff (reset)
      (apbWr && paddr == asf_pkg::ADDR_SLPCTL && !pwdata[0] && !sleepExpire && !s_q.flags[7])
      |=> !s_q.sleepReq && !s_q.flags[asf_pkg::ST_SLPDONE];
   endproperty
   a_earlyExit: assert property (p_earlyExit) else $error("early exit set done");
   property p_expire;
      @(posedge clk_sys) disable iff (reset)
      sleepExpire |=> !s_q.sleepReq && s_q.flags[asf_pkg::ST_SLPDONE];
   endproperty
   a_expire: assert property (p_expire) else $error("expiry not handled");
   property p_sleepNoFault;
      @(posedge clk_sys) disable iff (reset)
      (s_q.sleepReq && s_q.fault == asf_pkg::FS_NORMAL) |=> s_q.fault == asf_pkg::FS_NORMAL;
   endproperty
   a_sleepNoFault: assert property (p_sleepNoFault) else $error("fault entered in sleep");
   property p_ldoFault;
      @(posedge clk_sys) disable iff (reset)
      (s_q.fault == asf_pkg::FS_LDO) |=> boostEn && otsMonEn && !photoAmpEn && !sounderOscOn;
   endproperty
   a_ldoFault: assert property (p_ldoFault) else $error("regulator fault gating wrong");
   property p_otsFault;
      @(posedge clk_sys) disable iff (reset)
      (s_q.fault == asf_pkg::FS_OTS) |=> !ldoEn && !boostEn;
   endproperty
   a_otsFault: assert property (p_otsFault) else $error("temperature fault gating wrong");
   c_sleepExpire: cover property (@(posedge clk_sys) disable iff (reset) sleepExpire);
   c_ldoFault: cover property (@(posedge clk_sys) disable iff (reset) s_q.fault == asf_pkg::FS_LDO);
   c_otsFault: cover property (@(posedge clk_sys) disable iff (reset) s_q.fault == asf_pkg::FS_OTS);
   c_statusRd: cover property (@(posedge clk_sys) disable iff (reset) statusRd && irq);
endmodule

// File: tb/asf_mcu_model.sv
// ----
// asf_mcu_model: host controller pins and slow clock
// ----
// assumes the bench sets the wanted pin levels
`timescale 1ns/1ps
module asf_mcu_model (
   // wanted levels
   input wire logic wantEn,
   input wire logic wantFb,
   // pins
   output logic sounder_enable_pin,
   output logic feedback_input,
   output logic lfClk
);
   assign sounder_enable_pin = wantEn;
   assign feedback_input = wantFb;
   // free running slow clock, period unrelated to clk_sys
   initial lfClk = 1'b0;
   always #21 lfClk = ~lfClk;
endmodule

// File: tb/test_asf_ctrl.sv
// ----
// test_asf_ctrl: bench for the front-end control block
// ----
// assumes apb answers with one wait state
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t %h %h", $time, g, e); end end
module test_asf_ctrl;
   logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, wantEn = 0, wantFb = 0, gpioIn = 0;
   logic pgRaw = 1, hot = 0, cool = 1, icLine = 0, alertIn = 0;
   logic boostEn, ldoEn, otsEn, alertOut, alertOeN, icDrive;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, err, sndEn, fbIn, lfClk, silverOut, brassOut, oscOn, battEn, biasOn, oscEn, gpioOut;
   int fail_count = 0, checks = 0;
   always #2 clk_sys = ~clk_sys;
   asf_mcu_model i_mcu (.wantEn(wantEn), .wantFb(wantFb), .sounder_enable_pin(sndEn), .feedback_input(fbIn),
      .lfClk(lfClk));
   asf_ctrl #(.LF_TICKS_PER_MS(2), .DEGLITCH_CYC(4), .MASK_CYC(20)) i_dut (.clk_sys(clk_sys), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sounder_enable_pin(sndEn), .feedback_input(fbIn), .led_drive_pin(1'b0),
      .interconnectLine(icLine), .ldoUvGoodRaw(pgRaw), .dieHot(hot), .dieCool(cool), .lfClk(lfClk), .gpioIn(gpioIn),
      .gpioOut(gpioOut), .gpioOeN(), .hostAlertIn(alertIn), .hostAlertOut(alertOut), .hostAlertOeN(alertOeN),
      .silver_output(silverOut), .brass_output(brassOut), .sounderOscOn(oscOn), .batteryLoadEn(battEn),
      .biasEn(biasOn), .osc8mEn(oscEn), .boostEn(boostEn), .ldoEn(ldoEn), .photoAmpEn(), .photoGainEn(), .ledRegEn(),
      .ledDriveEn(), .amuxEn(), .otsMonEn(otsEn), .interconnectDrive(icDrive));
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask
   // one apb transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic t_sounder();
      apb(1, asf_pkg::ADDR_CTRL, 32'h2);
      wantEn <= 1'b1;
      cyc(5);
      `CHK(oscOn, 1'b1)
      wantEn <= 1'b0;
      cyc(5);
      `CHK(oscOn, 1'b0)
      apb(1, asf_pkg::ADDR_CTRL, 32'h3);
      wantFb <= 1'b1;
      cyc(5);
      `CHK({silverOut, brassOut}, 2'b10)
      wantFb <= 1'b0;
      wantEn <= 1'b1;
      cyc(5);
      `CHK({silverOut, brassOut}, 2'b01)
      `CHK(oscOn, 1'b0)
      wantEn <= 1'b0;
      $display("sounder done");
   endtask
   task automatic t_bias();
      logic [31:0] v[3] = '{32'h8, 32'h20, 32'h0};
      logic [1:0] e[3] = '{2'b11, 2'b10, 2'b00};
      for (int i = 0; i < 3; i++)
      begin
         apb(1, asf_pkg::ADDR_CTRL, v[i]);
         cyc(2);
         `CHK({biasOn, oscEn}, e[i])
      end
      $display("bias done");
   endtask
   task automatic t_batt();
      apb(1, asf_pkg::ADDR_PINCFG, 32'h1);
      gpioIn <= 1'b1;
      cyc(5);
      `CHK(battEn, 1'b1)
      gpioIn <= 1'b0;
      apb(0, 8'h24, 32'h0);
      `CHK(err, 1'b1)
      `CHK(battEn, 1'b0)
      $display("battery done");
   endtask
   task automatic t_sleep();
      int n;
      n = 0;
      apb(1, asf_pkg::ADDR_PERLO, 32'h1);
      apb(1, asf_pkg::ADDR_MASK, 32'h80);
      apb(1, asf_pkg::ADDR_PINCFG, 32'h2);
      apb(1, asf_pkg::ADDR_SLPCTL, 32'h1);
      while (gpioOut !== 1'b1 && n++ < 400) cyc(1);
      `CHK(gpioOut, 1'b1)
      apb(0, asf_pkg::ADDR_SLPCTL, 32'h0);
      `CHK(rd[0], 1'b0)
      apb(0, asf_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[7], 1'b1)
      cyc(2);
      `CHK(gpioOut, 1'b0)
      // a 4 ms period cannot run out inside the short sleep, but would within the wait below
      apb(1, asf_pkg::ADDR_PERLO, 32'h4);
      apb(1, asf_pkg::ADDR_SLPCTL, 32'h1);
      apb(1, asf_pkg::ADDR_SLPCTL, 32'h0);
      cyc(100);
      apb(0, asf_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[8:7], 2'b00)
      $display("sleep done");
   endtask
   task automatic t_alert();
      apb(1, asf_pkg::ADDR_PINCFG, 32'h8);
      icLine <= 1'b1;
      cyc(5);
      `CHK({alertOut, alertOeN}, 2'b10)
      apb(1, asf_pkg::ADDR_PINCFG, 32'h18);
      alertIn <= 1'b1;
      cyc(5);
      `CHK({alertOeN, icDrive}, 2'b11)
      icLine <= 1'b0;
      alertIn <= 1'b0;
      apb(1, asf_pkg::ADDR_MASK, 32'h1);
      apb(1, asf_pkg::ADDR_PINCFG, 32'h4);
      cyc(2);
      `CHK({alertOut, alertOeN}, 2'b10)
      apb(0, asf_pkg::ADDR_STATUS, 32'h0);
      cyc(2);
      `CHK(alertOut, 1'b0)
      $display("alert done");
   endtask
   task automatic t_fault();
      apb(1, asf_pkg::ADDR_CTRL, 32'h1000);
      cyc(30);
      pgRaw <= 1'b0;
      cyc(20);
      `CHK({boostEn, ldoEn, otsEn}, 3'b111)
      apb(0, asf_pkg::ADDR_STATUS, 32'h0);
      `CHK({rd[11:10], rd[5]}, 3'b011)
      hot <= 1'b1;
      cool <= 1'b0;
      cyc(8);
      `CHK({boostEn, ldoEn}, 2'b00)
      hot <= 1'b0;
      cool <= 1'b1;
      pgRaw <= 1'b1;
      cyc(4);
      apb(0, asf_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[11:10], 2'h2)
      cyc(10);
      apb(0, asf_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[11:10], 2'h1)
      apb(0, asf_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[11:10], 2'h0)
      $display("fault done");
   endtask
   task automatic end_of_test();
      $display("checks %0d bad %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      cyc(3);
      reset <= 1'b0;
      cyc(1);
      t_sounder();
      t_bias();
      t_batt();
      t_sleep();
      t_alert();
      t_fault();
      end_of_test();
   end
   // watchdog sized well past the expected run
   initial
   begin
      #40000;
      fail_count++;
      end_of_test();
   end
endmodule
